/* File: tdd_audio_packet_exchange.sv */
// Notes on behaviour
// - payload body 255 bytes, two codes each
// - first data byte seeds the decoder predictor
// - master encodes samples from end of init
// - full transmit buffer raises buffer-full flag
// - fill only the buffer not being sent
// - master turns to receive after sending
// - master timeout: null fill, back to transmit
// - decoding starts right after reception
// - slave receives first, timed by master
// - slave timeout: null fill, stay receiving
// - slave transmits only after good reception
// - sample tick drives sample, pwm, pack, unpack
// - send preamble, sync, then 256 bytes
// - hunt preamble and sync, store 256 bytes
// - filter mode frees then locks filter, no payload
// - cipher start may block or return at once
// - preamble is 18 alternating bytes
// - sync byte is 01011010
// - two zero bytes follow the payload
`timescale 1ns/1ps
`default_nettype none
`include "tdd_audio_consts.svh"

module tdd_audio_packet_exchange
  import tdd_audio_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYCLES = `SYNC_TIMEOUT_CYC
) (
  input wire logic I_CLK, // system clock
  input wire logic I_RESET, // synchronous reset, high
  input wire logic I_IS_MASTER, // unit role, high for master
  input wire logic I_INIT_DONE, // local init finished
  input wire logic I_FILTER_MODE, // next receive is a filter lock step
  input wire logic I_SAMPLE_TICK, // sampling period tick
  input wire logic [7:0] I_ADC_SAMPLE, // unsigned input sample
  input wire logic [3:0] I_ENC_CODE, // code from difference encoder
  input wire logic [7:0] I_DEC_SAMPLE, // sample from difference decoder
  input wire logic I_TX_BYTE_REQ, // modem ready for next tx byte
  input wire byte_beat_t I_RX_BYTE, // received byte from modem
  input wire logic I_CIPHER_WAIT, // wait for cipher before sending
  input wire logic I_CIPHER_DONE, // cipher operation finished
  output logic O_ADC_START, // start conversion pulse
  output logic O_ENC_STEP, // encoder step pulse
  output logic [7:0] O_ENC_SAMPLE, // sample to encoder
  output logic O_DEC_STEP, // decoder step pulse
  output logic [3:0] O_DEC_CODE, // code to decoder
  output logic O_DEC_LOAD, // load decoder predictor pulse
  output logic [7:0] O_DEC_SEED, // predictor start value
  output logic [7:0] O_PWM_DUTY, // output duty cycle
  output logic O_RF_TX_MODE, // radio in transmit, else receive
  output logic [7:0] O_TX_BYTE, // byte to modem
  output logic O_TX_BYTE_VALID, // tx byte load pulse
  output logic O_FILTER_LOCK, // averaging filter locked
  output logic O_BUF_FULL, // a transmit buffer is full
  output logic O_RX_TIMEOUT, // sync timeout pulse
  output cipher_ctl_t O_CIPHER // cipher start control
);

  // ============================================================
  // state and storage
  link_state_t state_q;
  logic [7:0] tx_mem [0:1][0:255];
  logic [7:0] rx_mem [0:1][0:255];
  logic fill_sel_q, send_sel_q, rx_sel_q, play_sel_q;
  logic [8:0] nib_q;
  logic [3:0] code_hold_q;
  logic full_q;
  logic [8:0] cnt_q;
  logic [31:0] tmo_q;
  logic [7:0] shift_q;
  logic play_ok_q;
  logic [8:0] play_idx_q;
  logic fill_busy_q;
  logic [7:0] fill_idx_q;
  logic filter_step_q;
  logic cipher_busy_q;
  logic wr_ok;
  assign wr_ok = (state_q != ST_INIT);

  // ============================================================
  // sample tick: sample, encode, pack
  always_ff @(posedge I_CLK) begin
    O_ADC_START <= I_SAMPLE_TICK && wr_ok;
    O_ENC_STEP <= I_SAMPLE_TICK && wr_ok;
    if (I_RESET) begin
      O_ENC_SAMPLE <= `ZERO_BYTE;
    end else if (I_SAMPLE_TICK) begin
      O_ENC_SAMPLE <= I_ADC_SAMPLE;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      nib_q <= '0;
      fill_sel_q <= 1'b0;
      full_q <= 1'b0;
      code_hold_q <= '0;
    end else begin
      if (state_q == ST_TX_SYNC) begin
        full_q <= 1'b0;
      end
      if (O_ENC_STEP && (!full_q || fill_sel_q != send_sel_q)) begin
        if (nib_q == '0) begin
          tx_mem[fill_sel_q][0] <= O_ENC_SAMPLE;
          nib_q <= 9'd1;
        end else if (nib_q[0]) begin
          code_hold_q <= I_ENC_CODE;
          nib_q <= nib_q + 9'd1;
        end else begin
          tx_mem[fill_sel_q][nib_q[8:1]] <= {code_hold_q, I_ENC_CODE};
          if (nib_q == `LAST_NIBBLE_IDX) begin
            nib_q <= '0;
            fill_sel_q <= ~fill_sel_q;
            full_q <= 1'b1;
          end else begin
            nib_q <= nib_q + 9'd1;
          end
        end
      end
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_BUF_FULL <= 1'b0;
    end else begin
      O_BUF_FULL <= full_q;
    end
  end

  // ============================================================
  // cipher start control
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_CIPHER <= '0;
      cipher_busy_q <= 1'b0;
    end else begin
      O_CIPHER.start <= (state_q == ST_TX_WAIT) && full_q && !cipher_busy_q;
      O_CIPHER.wait_done <= I_CIPHER_WAIT;
      O_CIPHER.encrypt <= 1'b1;
      if (O_CIPHER.start) begin
        cipher_busy_q <= 1'b1;
      end else if (I_CIPHER_DONE || state_q != ST_TX_WAIT) begin
        cipher_busy_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // link sequencer
  always_ff @(posedge I_CLK) begin
    O_TX_BYTE_VALID <= 1'b0;
    O_RX_TIMEOUT <= 1'b0;
    O_DEC_LOAD <= 1'b0;
    if (I_RESET) begin
      state_q <= ST_INIT;
      cnt_q <= '0;
      tmo_q <= '0;
      shift_q <= '0;
      send_sel_q <= 1'b0;
      rx_sel_q <= 1'b0;
      play_sel_q <= 1'b0;
      play_ok_q <= 1'b0;
      O_RF_TX_MODE <= 1'b0;
      O_TX_BYTE <= `ZERO_BYTE;
      O_FILTER_LOCK <= 1'b0;
      O_DEC_SEED <= `NULL_SAMPLE;
      filter_step_q <= 1'b0;
      fill_busy_q <= 1'b0;
    end else begin
      if (fill_busy_q && fill_idx_q == `LAST_PAYLOAD_IDX) begin
        fill_busy_q <= 1'b0;
      end
      // null fill shares this process so the receive pair has one writer
      if (fill_busy_q && state_q != ST_RX_DATA) begin
        rx_mem[0][fill_idx_q] <= (fill_idx_q == '0) ? `NULL_SAMPLE : `NULL_CODE_BYTE;
        rx_mem[1][fill_idx_q] <= (fill_idx_q == '0) ? `NULL_SAMPLE : `NULL_CODE_BYTE;
      end
      unique case (state_q)
        ST_INIT: begin
          if (I_INIT_DONE) begin
            state_q <= I_IS_MASTER ? ST_TX_WAIT : ST_RX_HUNT;
            O_RF_TX_MODE <= I_IS_MASTER;
            tmo_q <= '0;
          end
        end
        ST_TX_WAIT: begin
          O_RF_TX_MODE <= 1'b1;
          if (full_q && (!I_CIPHER_WAIT || (cipher_busy_q && I_CIPHER_DONE))) begin
            send_sel_q <= ~fill_sel_q;
            cnt_q <= '0;
            state_q <= ST_TX_PRE;
          end
        end
        ST_TX_PRE: begin
          if (I_TX_BYTE_REQ) begin
            O_TX_BYTE <= `PREAMBLE_PATTERN;
            O_TX_BYTE_VALID <= 1'b1;
            if (cnt_q == 9'(`PREAMBLE_BYTES - 5'd1)) begin
              state_q <= ST_TX_SYNC;
            end
            cnt_q <= cnt_q + 9'd1;
          end
        end
        ST_TX_SYNC: begin
          if (I_TX_BYTE_REQ) begin
            O_TX_BYTE <= `SYNC_PATTERN;
            O_TX_BYTE_VALID <= 1'b1;
            cnt_q <= '0;
            state_q <= ST_TX_DATA;
          end
        end
        ST_TX_DATA: begin
          if (I_TX_BYTE_REQ) begin
            O_TX_BYTE <= tx_mem[send_sel_q][cnt_q[7:0]];
            O_TX_BYTE_VALID <= 1'b1;
            if (cnt_q == `PAYLOAD_BYTES - 9'd1) begin
              cnt_q <= '0;
              state_q <= ST_TX_TAIL;
            end else begin
              cnt_q <= cnt_q + 9'd1;
            end
          end
        end
        ST_TX_TAIL: begin
          if (I_TX_BYTE_REQ) begin
            O_TX_BYTE <= `ZERO_BYTE;
            O_TX_BYTE_VALID <= 1'b1;
            cnt_q <= cnt_q + 9'd1;
          end else if (cnt_q == 9'(`TAIL_BYTES)) begin
            O_RF_TX_MODE <= 1'b0;
            tmo_q <= '0;
            filter_step_q <= I_FILTER_MODE;
            O_FILTER_LOCK <= I_FILTER_MODE ? 1'b0 : O_FILTER_LOCK;
            state_q <= ST_RX_HUNT;
          end
        end
        ST_RX_HUNT: begin
          tmo_q <= tmo_q + 32'd1;
          if (I_RX_BYTE.valid) begin
            shift_q <= I_RX_BYTE.data;
          end
          if (I_RX_BYTE.valid && I_RX_BYTE.data == `SYNC_PATTERN
              && shift_q == `PREAMBLE_PATTERN) begin
            cnt_q <= '0;
            if (filter_step_q) begin
              O_FILTER_LOCK <= 1'b1;
              filter_step_q <= 1'b0;
              state_q <= I_IS_MASTER ? ST_TX_WAIT : ST_RX_HUNT;
              tmo_q <= '0;
            end else begin
              state_q <= ST_RX_DATA;
            end
          end else if (tmo_q >= SYNC_TIMEOUT_CYCLES - 1) begin
            O_RX_TIMEOUT <= 1'b1;
            fill_busy_q <= 1'b1;
            play_ok_q <= 1'b0;
            tmo_q <= '0;
            if (I_IS_MASTER) begin
              state_q <= ST_TX_WAIT;
              O_RF_TX_MODE <= 1'b1;
            end else begin
              state_q <= ST_RX_HUNT;
            end
          end
        end
        ST_RX_DATA: begin
          if (I_RX_BYTE.valid) begin
            rx_mem[rx_sel_q][cnt_q[7:0]] <= I_RX_BYTE.data;
            if (cnt_q == `PAYLOAD_BYTES - 9'd1) begin
              rx_sel_q <= ~rx_sel_q;
              play_sel_q <= rx_sel_q;
              play_ok_q <= 1'b1;
              O_DEC_LOAD <= 1'b1;
              O_DEC_SEED <= rx_mem[rx_sel_q][0];
              state_q <= ST_TX_WAIT;
              O_RF_TX_MODE <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 9'd1;
            end
          end
        end
      endcase
    end
  end

  // ============================================================
  // null fill index for the receive pair
  always_ff @(posedge I_CLK) begin
    if (I_RESET || !fill_busy_q) begin
      fill_idx_q <= '0;
    end else begin
      fill_idx_q <= fill_idx_q + 8'd1;
    end
  end

  // ============================================================
  // unpack: one code per tick, pwm from decoder
  always_ff @(posedge I_CLK) begin
    O_DEC_STEP <= 1'b0;
    if (I_RESET) begin
      play_idx_q <= 9'd2;
      O_DEC_CODE <= '0;
      O_PWM_DUTY <= `NULL_SAMPLE;
    end else begin
      if (O_DEC_LOAD) begin
        play_idx_q <= 9'd2;
      end else if (I_SAMPLE_TICK) begin
        O_PWM_DUTY <= play_ok_q ? I_DEC_SAMPLE : `NULL_SAMPLE;
        if (play_ok_q && play_idx_q <= `LAST_NIBBLE_IDX + 9'd1) begin
          O_DEC_CODE <= play_idx_q[0] ? rx_mem[play_sel_q][play_idx_q[8:1]][3:0]
                                      : rx_mem[play_sel_q][play_idx_q[8:1]][7:4];
          O_DEC_STEP <= 1'b1;
          play_idx_q <= play_idx_q + 9'd1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: tdd_audio_consts.svh */
`ifndef TDD_AUDIO_CONSTS_SVH
`define TDD_AUDIO_CONSTS_SVH
`define PREAMBLE_BYTES 5'd18
`define PREAMBLE_PATTERN 8'h55
`define SYNC_PATTERN 8'h5A
`define PAYLOAD_BYTES 9'd256
`define LAST_PAYLOAD_IDX 8'hFF
`define TAIL_BYTES 2'd2
`define ZERO_BYTE 8'h00
`define NULL_SAMPLE 8'h80
`define NULL_CODE_BYTE 8'h00
`define LAST_NIBBLE_IDX 9'd510
`define SYNC_TIMEOUT_US 32'd20000
`define CLK_MHZ 32'd100
`define SYNC_TIMEOUT_CYC (`SYNC_TIMEOUT_US * `CLK_MHZ)
`endif

/* File: tdd_audio_pkg.sv */
package tdd_audio_pkg;
  typedef enum logic [2:0] {
    ST_INIT,
    ST_TX_WAIT,
    ST_TX_PRE,
    ST_TX_SYNC,
    ST_TX_DATA,
    ST_TX_TAIL,
    ST_RX_HUNT,
    ST_RX_DATA
  } link_state_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;
  typedef struct packed {
    logic start;
    logic wait_done;
    logic encrypt;
  } cipher_ctl_t;
endpackage

/* File: tdd_audio_packet_exchange_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker
module tdd_audio_packet_exchange_chk
  import tdd_audio_pkg::*;
(
  input wire logic I_CLK, // clock
  input wire logic I_RESET, // reset
  input wire logic I_IS_MASTER, // role
  input wire logic I_SAMPLE_TICK, // tick
  input wire logic I_TX_BYTE_REQ, // byte wanted
  input wire byte_beat_t I_RX_BYTE, // rx byte
  input wire logic O_ADC_START, // conversion
  input wire logic O_ENC_STEP, // encode
  input wire logic O_DEC_LOAD, // seed load
  input wire logic O_RF_TX_MODE, // tx mode
  input wire logic O_TX_BYTE_VALID, // tx load
  input wire logic O_RX_TIMEOUT // timeout
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic got_q;
  // remembers a good reception since the last send
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      got_q <= 1'b0;
    end else if (O_DEC_LOAD) begin
      got_q <= 1'b1;
    end else if (O_RF_TX_MODE) begin
      got_q <= 1'b0;
    end
  end
  sequence s_slave_to;
    !I_IS_MASTER && O_RX_TIMEOUT;
  endsequence
  sequence s_sent;
    I_IS_MASTER && $fell(O_RF_TX_MODE);
  endsequence
  property p_enc;
    O_ENC_STEP |-> $past(I_SAMPLE_TICK);
  endproperty
  property p_adc;
    O_ADC_START |-> $past(I_SAMPLE_TICK);
  endproperty
  property p_txv;
    O_TX_BYTE_VALID |-> $past(I_TX_BYTE_REQ) && O_RF_TX_MODE;
  endproperty
  property p_load;
    O_DEC_LOAD |-> $past(I_RX_BYTE.valid) && !$past(O_RF_TX_MODE);
  endproperty
  property p_slv_to;
    s_slave_to |=> !O_RF_TX_MODE [*4];
  endproperty
  property p_to_pulse;
    O_RX_TIMEOUT |=> !O_RX_TIMEOUT;
  endproperty
  property p_reply;
    $rose(O_RF_TX_MODE) && !I_IS_MASTER |-> got_q || O_DEC_LOAD;
  endproperty
  property p_mst_rx;
    s_sent |-> !O_TX_BYTE_VALID [*8];
  endproperty
  a_enc: assert property (p_enc) else $error("encode without tick");
  a_adc: assert property (p_adc) else $error("sample without tick");
  a_txv: assert property (p_txv) else $error("tx byte unrequested");
  a_load: assert property (p_load) else $error("load without byte");
  a_slv_to: assert property (p_slv_to) else $error("slave sent on timeout");
  a_to_pulse: assert property (p_to_pulse) else $error("timeout not a pulse");
  a_reply: assert property (p_reply) else $error("slave sent unprompted");
  a_mst_rx: assert property (p_mst_rx) else $error("byte after send end");
endmodule
bind tdd_audio_packet_exchange tdd_audio_packet_exchange_chk chk (.*);
`default_nettype wire

/* File: tdd_audio_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// far radio unit
module tdd_audio_peer
  import tdd_audio_pkg::*;
#(
  parameter int GAP = 8
) (
  input wire logic I_CLK, // clock
  input wire logic O_RF_TX_MODE, // block sends
  input wire logic O_TX_BYTE_VALID, // byte load
  input wire logic [7:0] O_TX_BYTE, // byte
  output logic I_TX_BYTE_REQ, // next byte wanted
  output byte_beat_t I_RX_BYTE // byte to block
);
  logic [7:0] got[$];
  int n = 0;
  initial begin
    I_TX_BYTE_REQ = 1'b0;
    I_RX_BYTE = 9'h000;
  end
  always @(negedge I_CLK) begin
    n <= (n + 1) % GAP;
    I_TX_BYTE_REQ <= O_RF_TX_MODE && n == 0;
  end
  always @(posedge I_CLK) begin
    if (O_TX_BYTE_VALID) begin
      got.push_back(O_TX_BYTE);
    end
  end
  // idle data shows the inverse of the last byte
  task automatic send(input logic [7:0] seed);
    logic [7:0] b;
    for (int i = 0; i < 275; i++) begin
      repeat (GAP - 1) @(negedge I_CLK);
      b = i < 18 ? 8'h55 : i == 18 ? 8'h5A : i == 19 ? seed : 8'h21;
      I_RX_BYTE <= {1'b1, b};
      @(negedge I_CLK);
      I_RX_BYTE <= {1'b0, ~b};
    end
  endtask
endmodule
`default_nettype wire

/* File: tdd_audio_packet_exchange_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tdd_audio_packet_exchange_tb_top;
  import tdd_audio_pkg::*;
  logic I_CLK, I_RESET, I_IS_MASTER, I_INIT_DONE, I_FILTER_MODE;
  logic I_SAMPLE_TICK, I_TX_BYTE_REQ, I_CIPHER_WAIT, I_CIPHER_DONE;
  logic [7:0] I_ADC_SAMPLE, I_DEC_SAMPLE, O_ENC_SAMPLE, O_DEC_SEED;
  logic [7:0] O_PWM_DUTY, O_TX_BYTE;
  logic [3:0] I_ENC_CODE, O_DEC_CODE;
  logic O_ADC_START, O_ENC_STEP, O_DEC_STEP, O_DEC_LOAD, O_RF_TX_MODE;
  logic O_TX_BYTE_VALID, O_FILTER_LOCK, O_BUF_FULL, O_RX_TIMEOUT;
  byte_beat_t I_RX_BYTE;
  cipher_ctl_t O_CIPHER;
  int n_mismatch = 0;
  int n_tests = 0;
  int tc = 0;
  tdd_audio_packet_exchange #(.SYNC_TIMEOUT_CYCLES(200)) dut (.*);
  tdd_audio_peer peer (.*);
  // ====
  // clock and sample tick
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  always @(negedge I_CLK) begin
    tc <= (tc + 1) % 4;
    I_SAMPLE_TICK <= tc == 0;
    I_ADC_SAMPLE <= I_ADC_SAMPLE + 8'h03;
  end
  // ====
  // helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wait_sig(ref logic s, input logic v, input int lim, input string nm);
    for (int i = 0; i < lim && s !== v; i++) @(negedge I_CLK);
    chk(nm, {15'h0000, v}, {15'h0000, s});
  endtask
  task automatic do_reset(input logic m);
    I_RESET <= 1'b1;
    I_IS_MASTER <= m;
    I_INIT_DONE <= 1'b0;
    repeat (8) @(negedge I_CLK);
    I_RESET <= 1'b0;
    @(negedge I_CLK);
    I_INIT_DONE <= 1'b1;
  endtask
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_master_tx;
    do_reset(1'b1);
    peer.got.delete();
    wait_sig(O_BUF_FULL, 1'b1, 4000, "buf_full");
    wait_sig(O_RF_TX_MODE, 1'b1, 100, "tx_mode");
    wait_sig(O_RF_TX_MODE, 1'b0, 4000, "rx_mode");
    chk("count", 16'd277, 16'(peer.got.size()));
    for (int i = 0; i < 18; i++) chk("pre", 16'h0055, {8'h00, peer.got[i]});
    chk("sync", 16'h005A, {8'h00, peer.got[18]});
    chk("code", 16'h0033, {8'h00, peer.got[20]});
    chk("tail", 16'h0000, {peer.got[275], peer.got[276]});
    wait_sig(O_RX_TIMEOUT, 1'b1, 400, "timeout");
    repeat (8) @(negedge I_CLK);
    chk("pwm", 16'h0080, {8'h00, O_PWM_DUTY});
    wait_sig(O_RF_TX_MODE, 1'b1, 5000, "back_tx");
  endtask
  task automatic t_master_rx;
    wait_sig(O_RF_TX_MODE, 1'b0, 4000, "rx2");
    peer.send(8'h3C);
    wait_sig(O_DEC_LOAD, 1'b1, 20, "load");
    chk("seed", 16'h003C, {8'h00, O_DEC_SEED});
  endtask
  task automatic t_slave;
    logic bad;
    bad = 1'b0;
    do_reset(1'b0);
    wait_sig(O_RX_TIMEOUT, 1'b1, 400, "s_to");
    repeat (300) begin
      @(negedge I_CLK);
      bad |= O_RF_TX_MODE !== 1'b0;
    end
    chk("s_quiet", 16'h0000, {15'h0000, bad});
    peer.send(8'h77);
    wait_sig(O_DEC_LOAD, 1'b1, 20, "s_load");
    wait_sig(O_RF_TX_MODE, 1'b1, 4000, "s_reply");
  endtask
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    I_RESET = 1'b1;
    I_IS_MASTER = 1'b1;
    I_INIT_DONE = 1'b0;
    I_FILTER_MODE = 1'b0;
    I_SAMPLE_TICK = 1'b0;
    I_ENC_CODE = 4'h3;
    I_DEC_SAMPLE = 8'h40;
    I_ADC_SAMPLE = 8'h10;
    I_CIPHER_WAIT = 1'b0;
    I_CIPHER_DONE = 1'b0;
    t_master_tx();
    t_master_rx();
    t_slave();
    complete_run();
  end
endmodule
`default_nettype wire
